// ### design/lcd_port_pkg.sv
// Shared types and constants for the LCD serial command/data port
package lcd_port_pkg;

	// Clock and start-up timing
	localparam int unsigned CLK_FREQ_HZ = 25_000_000;
	localparam int unsigned START_DELAY_MS = 10;
	localparam int unsigned START_DELAY_CYCLES = (CLK_FREQ_HZ / 1000) * START_DELAY_MS;
	localparam int unsigned START_CNT_W = 18;

	// Serial byte framing
	localparam logic [2:0] BIT_FIRST = 3'h0;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [2:0] BIT_STEP = 3'h1;
	localparam logic DC_COMMAND = 1'h0;
	localparam logic DC_DATA = 1'h1;

	// Frame memory geometry
	localparam logic [7:0] FM_COLS = 8'h84;
	localparam logic [7:0] FM_ROWS = 8'ha2;
	localparam int unsigned FM_DEPTH = 21384;
	localparam int unsigned FM_ADDR_W = 15;
	localparam int unsigned PIXEL_W = 18;
	localparam int unsigned CHAN_W = 6;
	localparam logic [1:0] PHASE_FIRST = 2'h0;
	localparam logic [1:0] PHASE_LAST = 2'h2;
	localparam logic [1:0] PHASE_STEP = 2'h1;
	localparam logic [7:0] COORD_STEP = 8'h01;
	localparam logic [7:0] COORD_ZERO = 8'h00;

	// Buffer shape
	localparam int unsigned BUF_DEPTH = 2;

	// Pins of the serial link, as sampled
	typedef struct packed {
		logic cs_n;
		logic scl;
		logic sda;
		logic dc;
		logic hw_reset_n;
	} pins_s;

	// Deselected, held in reset: safe value for the synchroniser at reset
	localparam pins_s PINS_IDLE = '{cs_n: 1'h1, scl: 1'h0, sda: 1'h0, dc: 1'h0, hw_reset_n: 1'h0};

	// One received byte with its command/data flag
	typedef struct packed {
		logic is_data;
		logic [7:0] value;
	} byte_s;

	localparam int unsigned BYTE_W = $bits(byte_s);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_SHIFT,
		ST_ABORT
	} port_state_e;

endpackage

// ### design/byte_fifo2.sv
// Small valid/ready buffer holding received bytes
`timescale 1ns/1ps
module byte_fifo2 #(
	parameter int unsigned WIDTH = 9,
	parameter int unsigned DEPTH = 2
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Filling side
	input wire logic in_valid_i,
	output logic in_ready_o,
	input wire logic [WIDTH-1:0] in_data_i,
	// Draining side
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [WIDTH-1:0] out_data_o
);

	localparam int unsigned PTR_W = (DEPTH > 1) ? $clog2(DEPTH) : 1;
	localparam int unsigned CNT_W = $clog2(DEPTH + 1);
	localparam logic [PTR_W-1:0] PTR_LAST = PTR_W'(DEPTH - 1);
	localparam logic [CNT_W-1:0] CNT_FULL = CNT_W'(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] slot;
		logic [PTR_W-1:0] wr_ptr;
		logic [PTR_W-1:0] rd_ptr;
		logic [CNT_W-1:0] count;
	} fifo_s;

	fifo_s q;
	fifo_s d;
	logic do_push;
	logic do_pop;

	// Pointer advance with wrap for any depth
	function automatic logic [PTR_W-1:0] ptr_next(input logic [PTR_W-1:0] p);
		ptr_next = (p == PTR_LAST) ? '0 : PTR_W'(p + 1'b1);
	endfunction

	// Honest full and empty flags
	assign in_ready_o = (q.count != CNT_FULL);
	assign out_valid_o = (q.count != '0);
	assign out_data_o = q.slot[q.rd_ptr];
	assign do_push = in_valid_i & in_ready_o;
	assign do_pop = out_valid_o & out_ready_i;

	// Next state of slots, pointers and fill count
	always_comb begin
		d = q;
		if (do_push) begin
			d.slot[q.wr_ptr] = in_data_i;
			d.wr_ptr = ptr_next(q.wr_ptr);
		end
		if (do_pop) begin
			d.rd_ptr = ptr_next(q.rd_ptr);
		end
		if (do_push && !do_pop) begin
			d.count = CNT_W'(q.count + 1'b1);
		end else if (do_pop && !do_push) begin
			d.count = CNT_W'(q.count - 1'b1);
		end
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end

endmodule

// ### design/lcd_serial_port.sv
// Four-wire serial receive port with frame memory for a colour LCD
// Notes on behaviour
// - Chip select high: idle, clocks ignored, byte cleared
// - Capture one bit per rising clock edge
// - Clock level at select fall is no edge
// - Command/data line low command, high data
// - Command/data line sampled at eighth rising edge
// - Hardware reset mid-byte discards the partial byte
// - After abort, wait reset high and reselect
// - Clock and data ignored while reset low
// - Frame memory 132x162 of 18-bit pixels
`timescale 1ns/1ps
module lcd_serial_port #(
	parameter int unsigned START_CYCLES = lcd_port_pkg::START_DELAY_CYCLES
) (
	// Clock and reset
	input wire logic ref_clk_i,
	input wire logic rstn_i,
	// Serial link pins
	input wire logic cs_n_i,
	input wire logic scl_i,
	input wire logic sda_i,
	input wire logic dc_i,
	input wire logic hw_reset_n_i,
	// Received byte stream
	output logic out_valid_o,
	input wire logic out_ready_i,
	output logic [7:0] out_byte_o,
	output logic out_is_data_o,
	output logic overrun_o,
	// Status
	output logic link_ready_o,
	// Frame memory read port
	input wire logic [lcd_port_pkg::FM_ADDR_W-1:0] rd_addr_i,
	output logic [lcd_port_pkg::PIXEL_W-1:0] rd_data_o
);

	localparam logic [lcd_port_pkg::START_CNT_W-1:0] START_LAST = lcd_port_pkg::START_CNT_W'(START_CYCLES - 1);

	typedef struct packed {
		lcd_port_pkg::pins_s pin1;
		lcd_port_pkg::pins_s pin2;
		logic scl_prev;
		lcd_port_pkg::port_state_e st;
		logic [2:0] bit_cnt;
		logic [6:0] shift;
		logic done_valid;
		lcd_port_pkg::byte_s done_byte;
		logic [1:0] px_phase;
		logic [2*lcd_port_pkg::CHAN_W-1:0] px_acc;
		logic [7:0] col;
		logic [7:0] row;
		logic wr_en;
		logic [lcd_port_pkg::FM_ADDR_W-1:0] wr_addr;
		logic [lcd_port_pkg::PIXEL_W-1:0] wr_data;
		logic [lcd_port_pkg::START_CNT_W-1:0] start_cnt;
		logic started;
		logic overrun;
	} state_s;

	state_s q;
	state_s d;
	lcd_port_pkg::pins_s pins_in;
	lcd_port_pkg::byte_s fifo_out;
	logic scl_rise;
	logic byte_done;
	logic fifo_in_ready;
	logic [lcd_port_pkg::PIXEL_W-1:0] frame_mem [lcd_port_pkg::FM_DEPTH];
	logic [lcd_port_pkg::PIXEL_W-1:0] rd_data_r;

	// Linear frame memory address of a pixel
	function automatic logic [lcd_port_pkg::FM_ADDR_W-1:0] pixel_addr(input logic [7:0] row, input logic [7:0] col);
		// Operands widened first so the row product cannot wrap at eight bits
		pixel_addr = lcd_port_pkg::FM_ADDR_W'(lcd_port_pkg::FM_ADDR_W'(row) * lcd_port_pkg::FM_ADDR_W'(lcd_port_pkg::FM_COLS)
			+ lcd_port_pkg::FM_ADDR_W'(col));
	endfunction

	// Colour channel taken from the upper bits of a data byte
	function automatic logic [lcd_port_pkg::CHAN_W-1:0] chan_of(input logic [7:0] b);
		chan_of = b[7:8-lcd_port_pkg::CHAN_W];
	endfunction

	// Raw pins gathered for the synchroniser
	assign pins_in = '{cs_n: cs_n_i, scl: scl_i, sda: sda_i, dc: dc_i, hw_reset_n: hw_reset_n_i};

	// Rising clock edge seen only on the second synchroniser stage
	assign scl_rise = q.pin2.scl & ~q.scl_prev;
	assign byte_done = (q.st == lcd_port_pkg::ST_SHIFT) & q.pin2.hw_reset_n & ~q.pin2.cs_n & scl_rise
		& (q.bit_cnt == lcd_port_pkg::BIT_LAST);

	// Next-state logic
	always_comb begin
		d = q;
		d.pin1 = pins_in;
		d.pin2 = q.pin1;
		d.scl_prev = q.pin2.scl;
		d.done_valid = 1'b0;
		d.wr_en = 1'b0;
		d.overrun = q.done_valid & ~fifo_in_ready;

		// Serial shifter
		case (q.st)
			lcd_port_pkg::ST_IDLE: begin
				d.bit_cnt = lcd_port_pkg::BIT_FIRST;
				d.shift = '0;
				if (!q.pin2.hw_reset_n) begin
					d.st = lcd_port_pkg::ST_ABORT;
				end else if (!q.pin2.cs_n) begin
					d.st = lcd_port_pkg::ST_SHIFT;
				end
			end
			lcd_port_pkg::ST_SHIFT: begin
				if (!q.pin2.hw_reset_n) begin
					d.st = lcd_port_pkg::ST_ABORT;
					d.bit_cnt = lcd_port_pkg::BIT_FIRST;
					d.shift = '0;
				end else if (q.pin2.cs_n) begin
					d.st = lcd_port_pkg::ST_IDLE;
					d.bit_cnt = lcd_port_pkg::BIT_FIRST;
					d.shift = '0;
				end else if (scl_rise) begin
					d.shift = {q.shift[5:0], q.pin2.sda};
					d.bit_cnt = 3'(q.bit_cnt + lcd_port_pkg::BIT_STEP);
					if (q.bit_cnt == lcd_port_pkg::BIT_LAST) begin
						d.done_valid = 1'b1;
						d.done_byte.value = {q.shift, q.pin2.sda};
						d.done_byte.is_data = q.pin2.dc;
						d.shift = '0;
					end
				end
			end
			lcd_port_pkg::ST_ABORT: begin
				d.bit_cnt = lcd_port_pkg::BIT_FIRST;
				d.shift = '0;
				if (q.pin2.hw_reset_n && q.pin2.cs_n) begin
					d.st = lcd_port_pkg::ST_IDLE;
				end
			end
			default: begin
				d.st = lcd_port_pkg::ST_IDLE;
				d.bit_cnt = lcd_port_pkg::BIT_FIRST;
				d.shift = '0;
			end
		endcase

		// Pixel assembly into frame memory
		if (q.done_valid) begin
			if (q.done_byte.is_data == lcd_port_pkg::DC_COMMAND) begin
				d.px_phase = lcd_port_pkg::PHASE_FIRST;
				d.col = lcd_port_pkg::COORD_ZERO;
				d.row = lcd_port_pkg::COORD_ZERO;
			end else if (q.px_phase == lcd_port_pkg::PHASE_LAST) begin
				d.wr_en = 1'b1;
				d.wr_addr = pixel_addr(q.row, q.col);
				d.wr_data = {q.px_acc, chan_of(q.done_byte.value)};
				d.px_phase = lcd_port_pkg::PHASE_FIRST;
				if (q.col == 8'(lcd_port_pkg::FM_COLS - lcd_port_pkg::COORD_STEP)) begin
					d.col = lcd_port_pkg::COORD_ZERO;
					if (q.row == 8'(lcd_port_pkg::FM_ROWS - lcd_port_pkg::COORD_STEP)) begin
						d.row = lcd_port_pkg::COORD_ZERO;
					end else begin
						d.row = 8'(q.row + lcd_port_pkg::COORD_STEP);
					end
				end else begin
					d.col = 8'(q.col + lcd_port_pkg::COORD_STEP);
				end
			end else begin
				d.px_acc = {q.px_acc[lcd_port_pkg::CHAN_W-1:0], chan_of(q.done_byte.value)};
				d.px_phase = 2'(q.px_phase + lcd_port_pkg::PHASE_STEP);
			end
		end

		// Start-up delay counter
		if (!q.started) begin
			d.start_cnt = lcd_port_pkg::START_CNT_W'(q.start_cnt + 1'b1);
			if (q.start_cnt == START_LAST) begin
				d.started = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			q <= '0;
			q.pin1 <= lcd_port_pkg::PINS_IDLE;
			q.pin2 <= lcd_port_pkg::PINS_IDLE;
		end else begin
			q <= d;
		end
	end

	// Frame memory write port
	always_ff @(posedge ref_clk_i) begin
		if (q.wr_en) begin
			frame_mem[q.wr_addr] <= q.wr_data;
		end
	end

	// Frame memory read port, out-of-range reads return zero
	always_ff @(posedge ref_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			rd_data_r <= '0;
		end else if (rd_addr_i < lcd_port_pkg::FM_ADDR_W'(lcd_port_pkg::FM_DEPTH)) begin
			rd_data_r <= frame_mem[rd_addr_i];
		end else begin
			rd_data_r <= '0;
		end
	end

	// Two-entry buffer between shifter and byte consumer
	byte_fifo2 #(
		.WIDTH(lcd_port_pkg::BYTE_W),
		.DEPTH(lcd_port_pkg::BUF_DEPTH)
	) u_byte_buf (
		.ref_clk_i(ref_clk_i),
		.rstn_i(rstn_i),
		.in_valid_i(q.done_valid),
		.in_ready_o(fifo_in_ready),
		.in_data_i(q.done_byte),
		.out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i),
		.out_data_o(fifo_out)
	);

	// Outputs
	assign out_byte_o = fifo_out.value;
	assign out_is_data_o = fifo_out.is_data;
	assign overrun_o = q.overrun;
	assign link_ready_o = q.started;
	assign rd_data_o = rd_data_r;

	// Deselect clears the partial byte within one cycle
	chk_cs_clears_byte: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		q.pin2.cs_n |=> (q.bit_cnt == lcd_port_pkg::BIT_FIRST) && (q.shift == '0))
		else $error("partial byte survived chip select high");

	// Every qualified rising edge advances the bit count
	chk_edge_counts_bit: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(q.st == lcd_port_pkg::ST_SHIFT) && q.pin2.hw_reset_n && !q.pin2.cs_n && scl_rise
		|=> q.bit_cnt == 3'($past(q.bit_cnt) + lcd_port_pkg::BIT_STEP))
		else $error("rising edge did not capture a bit");

	// Clock already high at select fall is not an edge
	chk_no_false_edge: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$fell(q.pin2.cs_n) && $past(q.pin2.scl) && q.pin2.scl |=> q.bit_cnt == lcd_port_pkg::BIT_FIRST)
		else $error("clock level at select fall taken as edge");

	// Flag of a completed byte follows the command/data line
	chk_dc_decode: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		byte_done |=> q.done_valid && (q.done_byte.is_data == $past(q.pin2.dc)))
		else $error("command/data flag wrongly decoded");

	// A byte completes only on the eighth edge
	chk_eighth_edge: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		$rose(q.done_valid) |-> $past(q.bit_cnt) == lcd_port_pkg::BIT_LAST && $past(scl_rise))
		else $error("byte completed on wrong edge");

	// Reset mid-byte discards the partial byte and produces nothing
	chk_reset_abort: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(q.st == lcd_port_pkg::ST_SHIFT) && !q.pin2.hw_reset_n
		|=> (q.st == lcd_port_pkg::ST_ABORT) && (q.bit_cnt == lcd_port_pkg::BIT_FIRST) && !q.done_valid)
		else $error("partial byte kept across hardware reset");

	// No new byte until reset high and chip select cycled
	chk_abort_wait: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		(q.st == lcd_port_pkg::ST_ABORT) && !q.pin2.cs_n |=> q.st != lcd_port_pkg::ST_SHIFT)
		else $error("shifting resumed without reselect");

	// Clock and data ignored throughout hardware reset
	chk_reset_ignores: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		!q.pin2.hw_reset_n [*2] |-> !byte_done && !q.done_valid)
		else $error("byte received while hardware reset low");

	// Third data byte of a pixel writes frame memory
	chk_pixel_write: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		q.done_valid && q.done_byte.is_data && (q.px_phase == lcd_port_pkg::PHASE_LAST)
		|=> q.wr_en && (q.wr_addr < lcd_port_pkg::FM_ADDR_W'(lcd_port_pkg::FM_DEPTH)))
		else $error("pixel not written to frame memory");

	// First bit received lands in the top of the byte
	chk_msb_first: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
		byte_done |=> q.done_byte.value == {$past(q.shift), $past(q.pin2.sda)})
		else $error("byte not assembled most significant bit first");

endmodule

// ### sim/lcd_host_model.sv
// Host model driving the four-wire serial display link
`timescale 1ns/1ps
module lcd_host_model #(
	parameter int HALF_CYC = 4
) (
	// Bench clock, pins change just after its rising edge
	input wire logic ref_clk_i,
	// Serial link pins
	output logic cs_n_o,
	output logic scl_o,
	output logic sda_o,
	output logic dc_o,
	output logic hw_reset_n_o
);
	// Deselected and out of reset at time zero
	initial begin
		cs_n_o = 1'h1;
		scl_o = 1'h0;
		sda_o = 1'h0;
		dc_o = 1'h0;
		hw_reset_n_o = 1'h1;
	end

	// Half a link clock period, 320 ns link period at 40 ns per cycle
	task automatic half();
		repeat (HALF_CYC) @(posedge ref_clk_i);
	endtask

	// Select with a chosen idle level of the clock
	task automatic select(input logic idle);
		@(posedge ref_clk_i);
		scl_o <= idle;
		half();
		cs_n_o <= 1'h0;
		half();
	endtask

	// Shift n bits, msb first, flag held over the byte
	task automatic shift(input logic [7:0] value, input int n, input logic dc);
		for (int i = 7; i > 7 - n; i--) begin
			scl_o <= 1'h0;
			sda_o <= value[i];
			dc_o <= dc;
			half();
			scl_o <= 1'h1;
			half();
		end
	endtask

	// Clock parks low, released lines show the inverse value
	task automatic deselect();
		scl_o <= 1'h0;
		half();
		cs_n_o <= 1'h1;
		sda_o <= ~sda_o;
		dc_o <= ~dc_o;
		half();
	endtask

	// Pin reset with clock and data wiggling meanwhile
	task automatic hw_reset(input int toggles);
		hw_reset_n_o <= 1'h0;
		half();
		repeat (toggles) begin
			scl_o <= ~scl_o;
			sda_o <= ~sda_o;
			half();
		end
		hw_reset_n_o <= 1'h1;
		half();
	endtask
endmodule

// ### sim/testbench.sv
// Self-checking bench for the LCD serial receive port
`timescale 1ns/1ps
module testbench;
	localparam int unsigned START = 16;
	logic ref_clk_i = 1'h0;
	logic rstn_i;
	logic cs_n, scl, sda, dc, hw_reset_n;
	logic out_valid_o, out_is_data_o, overrun_o, link_ready_o;
	logic out_ready_i;
	logic [7:0] out_byte_o;
	logic [lcd_port_pkg::FM_ADDR_W-1:0] rd_addr_i;
	logic [lcd_port_pkg::PIXEL_W-1:0] rd_data_o;
	lcd_port_pkg::byte_s exp_q[$];
	int n_errors = 0;
	int checks_done = 0;
	int n_overrun = 0;
	logic stall = 1'h0;

	// Clock, 40 ns period
	always #20 ref_clk_i = ~ref_clk_i;

	lcd_host_model host (.ref_clk_i(ref_clk_i), .cs_n_o(cs_n), .scl_o(scl), .sda_o(sda), .dc_o(dc),
		.hw_reset_n_o(hw_reset_n));

	lcd_serial_port #(.START_CYCLES(START)) dut (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n),
		.scl_i(scl), .sda_i(sda), .dc_i(dc), .hw_reset_n_i(hw_reset_n), .out_valid_o(out_valid_o),
		.out_ready_i(out_ready_i), .out_byte_o(out_byte_o), .out_is_data_o(out_is_data_o),
		.overrun_o(overrun_o), .link_ready_o(link_ready_o), .rd_addr_i(rd_addr_i), .rd_data_o(rd_data_o));

	task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
		checks_done++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value at %0t: %s seen %h expected %h", $time, what, seen, exp);
		end
	endtask

	task automatic end_of_test();
		$display("checks %0d errors %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask

	// Random consumer stalls unless held off
	always @(posedge ref_clk_i) out_ready_i <= !stall && ($urandom_range(3) != 0);

	// Oldest note compared whenever a byte is handed over
	always @(posedge ref_clk_i) begin
		if (overrun_o === 1'h1) n_overrun++;
		if (out_valid_o === 1'h1 && out_ready_i === 1'h1) begin
			if (exp_q.size() == 0) begin
				check(32'h1, 32'h0, "unexpected byte");
			end else begin
				check({out_is_data_o, out_byte_o}, exp_q.pop_front(), "byte");
			end
		end
	end

	// Note a byte, then shift it out
	task automatic send(input logic [7:0] v, input logic d);
		exp_q.push_back({d, v});
		host.shift(v, 8, d);
	endtask

	// Wait, bounded, for every noted byte to arrive
	task automatic drain();
		int k;
		k = 0;
		while ((exp_q.size() != 0 || out_valid_o !== 1'h0) && k < 400) begin
			@(posedge ref_clk_i);
			k++;
		end
		check(exp_q.size(), 32'h0, "bytes missing");
	endtask

	// Main sequence
	initial begin
		logic [7:0] v;
		logic [7:0] px[6];
		logic d;
		void'($urandom(64038));
		// Reset asserted, consumer idle, random read address before the first edge
		rstn_i <= 1'h0;
		out_ready_i <= 1'h0;
		rd_addr_i <= 15'($urandom);
		repeat (10) @(posedge ref_clk_i);
		rstn_i <= 1'h1;
		repeat (2) @(posedge ref_clk_i);
		check(link_ready_o, 1'h0, "link early");
		repeat (START + 4) @(posedge ref_clk_i);
		check(link_ready_o, 1'h1, "link ready");
		// Random bytes, both clock idle levels, back to back
		for (int i = 0; i < 6; i++) begin
			v = 8'($urandom);
			d = 1'($urandom);
			host.select(1'(i % 2));
			send(v, d);
			send(~v, ~d);
			host.deselect();
		end
		drain();
		// Two pixels after a command, plus an out-of-range read
		host.select(1'h0);
		send(8'h2c, lcd_port_pkg::DC_COMMAND);
		for (int i = 0; i < 6; i++) begin
			px[i] = 8'($urandom);
			send(px[i], lcd_port_pkg::DC_DATA);
		end
		host.deselect();
		drain();
		for (int i = 0; i < 3; i++) begin
			rd_addr_i <= (i == 2) ? 15'h5388 : 15'(i);
			repeat (2) @(posedge ref_clk_i);
			check(rd_data_o, (i == 2) ? 18'h0 : {px[3*i][7:2], px[3*i+1][7:2], px[3*i+2][7:2]}, "pixel");
		end
		// Partial byte cut off by deselect
		host.select(1'h1);
		host.shift(8'ha5, 4, 1'h1);
		host.deselect();
		host.select(1'h0);
		send(8'h3c, 1'h0);
		host.deselect();
		drain();
		// Pin reset mid-byte; select must be seen high again
		host.select(1'h0);
		host.shift(8'h5a, 5, 1'h1);
		host.hw_reset(6);
		host.shift(8'h77, 8, 1'h1);
		host.deselect();
		host.select(1'h0);
		send(8'h81, 1'h1);
		host.deselect();
		drain();
		// Buffer filled while stalled, third byte dropped
		stall <= 1'h1;
		host.select(1'h1);
		send(8'h11, 1'h1);
		send(8'h22, 1'h0);
		host.shift(8'h33, 8, 1'h1);
		host.deselect();
		check(out_valid_o, 1'h1, "held byte");
		check(n_overrun, 32'h1, "overrun pulses");
		stall <= 1'h0;
		drain();
		end_of_test();
	end

	// Watchdog against a hang
	initial begin
		#1_000_000;
		n_errors++;
		end_of_test();
	end
endmodule
